// [src/fcvs_pkg.sv]
// package: constants, types and register map of the frequency monitor
package fcvs_pkg;
  // measurement widths
  localparam int FW = 16;
  localparam int PW = 24;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PICKUP = 8'h04;
  localparam logic [7:0] OFS_DF = 8'h08;
  localparam logic [7:0] OFS_DT = 8'h0c;
  localparam logic [7:0] OFS_VMIN = 8'h10;
  localparam logic [7:0] OFS_VSTHR = 8'h14;
  localparam logic [7:0] OFS_REFPER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_NEED_LSB = 2;
  localparam int CTRL_W = 4;
  // irq bit positions
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_TRIP = 1;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [FW-1:0] PICKUP_RST = 16'h1388;
  localparam logic [FW-1:0] DF_RST = 16'h0050;
  localparam logic [FW-1:0] DT_RST = 16'h0064;
  localparam logic [FW-1:0] VMIN_RST = 16'h0100;
  localparam logic [FW-1:0] VSTHR_RST = 16'h000a;
  localparam logic [PW-1:0] REFPER_RST = 24'h07a120;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // release band of the pickup, in parts per ten thousand
  localparam logic [15:0] HYST_DEN = 16'h2710;
  localparam logic [15:0] HYST_DOWN = 16'h270b;
  localparam logic [15:0] HYST_UP = 16'h2715;
  // degrees in one full period
  localparam logic [8:0] ANG_FULL = 9'h168;
  // timing
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int VS_TRIP_MAX_MS = 60;
  typedef enum logic [1:0] {
    MODE_OFF, MODE_UNDER, MODE_OVER, MODE_SURGE
  } fcvs_mode_e;
  typedef enum logic [1:0] {
    ST_ARMED, ST_SUPV, ST_TRIP, ST_LOCK
  } fcvs_state_e;
  typedef struct packed {
    logic [FW-1:0] freq;
    logic [FW-1:0] volt;
    logic zc;
  } fcvs_meas_s;
endpackage

// [src/fcvs_monitor.sv]
// frequency change and vector surge protection element with apb registers
// Overview of operation
// - when all three phase-pair voltages are below the set minimum, no alarm or trip arises.
// - the single parameter set holds a pickup level, a change threshold and a supervision interval.
// - crossing the pickup unblocked raises the alarm at once and starts the interval timer.
// - a trip follows when, within the interval, the pickup still holds and the change is reached.
// - an interval that expires without the change gives no trip and blocks until pickup recrosses.
// - in vector surge mode every zero crossing restarts a cycle duration measurement.
// - each cycle duration is compared with a reference period and turned into a jump angle.
// - a jump angle above threshold, unblocked, raises alarm and trip with no delay.
// - a setting chooses whether one, two or all three phases must show the jump.
// - loss of any measuring phase inhibits the phase jump trip.
// - the low-voltage lockout acts before any phase jump result is evaluated.
// - a mains failure seen as a phase jump trips within 60 ms.
// - an overfrequency pickup releases only below 99.95 percent of its level.
//
// Our own choices: the register addresses and register access over APB.
module fcvs_monitor #(
  parameter int TICK_CYC = fcvs_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement front end
  input wire fcvs_pkg::fcvs_meas_s [2:0] meas,
  input wire logic [2:0] phase_lost,
  // external blocking command pin
  input wire logic ext_block,
  // protection outputs
  output logic alarm,
  output logic trip,
  output logic irq
);
  import fcvs_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [FW-1:0] pickup_r, df_r, dt_r, vmin_r, vsthr_r;
  logic [PW-1:0] refper_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, alarm_r, trip_r, irq_r;
  logic blk_s1_r, blk_s2_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [FW-1:0] sup_cnt_r;
  fcvs_state_e st_r, st_nxt;
  logic [2:0] pick_r, pick_now, beyond, released, chg_hit;
  logic [FW-1:0] start_f_r [3];
  logic [PW-1:0] vs_cnt_r [3];
  logic [2:0] seen_r, jump_r, jump_calc;
  fcvs_mode_e mode;
  logic uv, blk, df_mode, any_pick, chg_reached, expired;
  logic [1:0] njump, need;
  logic surge_cond, surge_trip, alarm_nxt, trip_nxt;
  logic wr_en, rd_en;

  assign mode = fcvs_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign df_mode = (mode == MODE_UNDER) || (mode == MODE_OVER);
  assign blk = blk_s2_r;
  assign uv = (meas[0].volt < vmin_r) && (meas[1].volt < vmin_r)
    && (meas[2].volt < vmin_r);

  // external block pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
    end else begin
      blk_s1_r <= ext_block;
      blk_s2_r <= blk_s1_r;
    end
  end

  // millisecond tick for the supervision interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // per-phase pickup with release band
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (mode == MODE_UNDER) begin
        beyond[i] = meas[i].freq < pickup_r;
        released[i] = 32'(meas[i].freq) * 32'(HYST_DEN)
          > 32'(pickup_r) * 32'(HYST_UP);
        chg_hit[i] = (meas[i].freq <= start_f_r[i])
          && (start_f_r[i] - meas[i].freq >= df_r);
      end else begin
        beyond[i] = meas[i].freq > pickup_r;
        released[i] = 32'(meas[i].freq) * 32'(HYST_DEN)
          < 32'(pickup_r) * 32'(HYST_DOWN);
        chg_hit[i] = (meas[i].freq >= start_f_r[i])
          && (meas[i].freq - start_f_r[i] >= df_r);
      end
      pick_now[i] = beyond[i] || (pick_r[i] && !released[i]);
    end
  end

  assign any_pick = |pick_now;
  assign chg_reached = |chg_hit;
  assign expired = (sup_cnt_r >= dt_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_r <= 3'h0;
    end else begin
      pick_r <= df_mode ? pick_now : 3'h0;
    end
  end

  // change-over-interval state machine
  always_comb begin
    st_nxt = st_r;
    if (uv || blk || !df_mode) begin
      st_nxt = ST_ARMED;
    end else begin
      unique case (st_r)
        ST_ARMED: if (any_pick) st_nxt = ST_SUPV;
        ST_SUPV: begin
          if (!any_pick) st_nxt = ST_ARMED;
          else if (chg_reached) st_nxt = ST_TRIP;
          else if (expired) st_nxt = ST_LOCK;
        end
        ST_TRIP: if (!any_pick) st_nxt = ST_ARMED;
        ST_LOCK: if (!any_pick) st_nxt = ST_ARMED;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_ARMED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // interval timer and frequencies captured at pickup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_cnt_r <= '0;
      for (int i = 0; i < 3; i++) start_f_r[i] <= '0;
    end else if (st_nxt == ST_SUPV && st_r != ST_SUPV) begin
      sup_cnt_r <= '0;
      for (int i = 0; i < 3; i++) start_f_r[i] <= meas[i].freq;
    end else if (st_nxt == ST_SUPV) begin
      if (tick_r && !expired) sup_cnt_r <= sup_cnt_r + 16'h1;
    end else begin
      sup_cnt_r <= '0;
    end
  end

  // cycle duration per phase and jump angle
  always_comb begin
    logic [PW-1:0] dev;
    dev = '0;
    for (int i = 0; i < 3; i++) begin
      dev = (vs_cnt_r[i] > refper_r) ? vs_cnt_r[i] - refper_r
        : refper_r - vs_cnt_r[i];
      jump_calc[i] = 48'(dev) * 48'(ANG_FULL)
        > 48'(vsthr_r) * 48'(refper_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 3'h0;
      jump_r <= 3'h0;
      for (int i = 0; i < 3; i++) vs_cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (meas[i].zc) begin
          vs_cnt_r[i] <= 24'h1;
          seen_r[i] <= !uv;
          jump_r[i] <= seen_r[i] && !uv && jump_calc[i];
        end else if (vs_cnt_r[i] != '1) begin
          vs_cnt_r[i] <= vs_cnt_r[i] + 24'h1;
        end
        if (uv || mode != MODE_SURGE) begin
          jump_r[i] <= 1'b0;
          seen_r[i] <= 1'b0;
        end
      end
    end
  end

  assign njump = 2'(jump_r[0]) + 2'(jump_r[1]) + 2'(jump_r[2]);
  assign need = (ctrl_r[CTRL_NEED_LSB +: 2] == 2'h3) ? 2'h3
    : ctrl_r[CTRL_NEED_LSB +: 2] + 2'h1;
  assign surge_cond = (mode == MODE_SURGE) && !uv && !blk
    && (njump >= need);
  assign surge_trip = surge_cond && !(|phase_lost);
  assign alarm_nxt = surge_cond || st_nxt == ST_SUPV || st_nxt == ST_TRIP;
  assign trip_nxt = surge_trip || st_nxt == ST_TRIP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= 1'b0;
      trip_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
      trip_r <= trip_nxt;
    end
  end

  // apb slave: one wait state, then pready
  assign wr_en = psel && penable && pready_r && pwrite;
  assign rd_en = psel && penable && !pready_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= rd_en;
      if (rd_en) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0;
        unique case (paddr)
          OFS_CTRL: prdata_r <= 32'(ctrl_r);
          OFS_PICKUP: prdata_r <= 32'(pickup_r);
          OFS_DF: prdata_r <= 32'(df_r);
          OFS_DT: prdata_r <= 32'(dt_r);
          OFS_VMIN: prdata_r <= 32'(vmin_r);
          OFS_VSTHR: prdata_r <= 32'(vsthr_r);
          OFS_REFPER: prdata_r <= 32'(refper_r);
          OFS_STATUS: prdata_r <= {25'h0, njump, uv, st_r, trip_r, alarm_r};
          OFS_IRQ_STAT: prdata_r <= 32'(irq_stat_r);
          OFS_IRQ_MASK: prdata_r <= 32'(irq_mask_r);
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      pickup_r <= PICKUP_RST;
      df_r <= DF_RST;
      dt_r <= DT_RST;
      vmin_r <= VMIN_RST;
      vsthr_r <= VSTHR_RST;
      refper_r <= REFPER_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
        OFS_PICKUP: pickup_r <= pwdata[FW-1:0];
        OFS_DF: df_r <= pwdata[FW-1:0];
        OFS_DT: dt_r <= pwdata[FW-1:0];
        OFS_VMIN: vmin_r <= pwdata[FW-1:0];
        OFS_VSTHR: vsthr_r <= pwdata[FW-1:0];
        OFS_REFPER: refper_r <= pwdata[PW-1:0];
        OFS_IRQ_MASK: irq_mask_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    logic [1:0] clr, ev;
    if (!presetn) begin
      irq_stat_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      clr = (wr_en && paddr == OFS_IRQ_STAT) ? pwdata[1:0] : 2'h0;
      ev = 2'h0;
      ev[IRQ_ALARM] = alarm_nxt && !alarm_r;
      ev[IRQ_TRIP] = trip_nxt && !trip_r;
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      irq_r <= |(((irq_stat_r & ~clr) | ev) & irq_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign alarm = alarm_r;
  assign trip = trip_r;
  assign irq = irq_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_pickup_start;
    df_mode && st_r == ST_ARMED && any_pick && !uv && !blk;
  endsequence
  sequence seq_supervising;
    alarm && st_r == ST_SUPV && sup_cnt_r == '0;
  endsequence
  sequence seq_jump_seen;
    mode == MODE_SURGE && njump >= need && !uv && !blk;
  endsequence

  a_uv_quiet: assert property (uv |=> !alarm && !trip)
    else $error("alarm or trip during undervoltage lockout");
  a_alarm_start: assert property (seq_pickup_start |=> seq_supervising)
    else $error("alarm or interval timer not started on pickup");
  a_trip_change: assert property (st_r == ST_SUPV && df_mode && any_pick
      && chg_reached && !uv && !blk |=> trip && st_r == ST_TRIP)
    else $error("no trip although change reached in interval");
  a_lock_no_trip: assert property (st_r == ST_LOCK && df_mode && any_pick
      && !uv && !blk |=> st_r == ST_LOCK && !trip)
    else $error("locked element left lock while pickup held");
  a_zc_restart: assert property (meas[0].zc |=> vs_cnt_r[0] == 24'h1)
    else $error("cycle measurement not restarted at crossing");
  a_jump_trip: assert property ((seq_jump_seen and !(|phase_lost))
      |=> alarm && trip)
    else $error("phase jump did not raise alarm and trip");
  a_phase_lost: assert property (mode == MODE_SURGE && |phase_lost
      |=> !trip)
    else $error("phase jump trip despite phase loss");
  a_uv_first: assert property (uv ##1 uv |-> jump_r == 3'h0)
    else $error("jump result kept under low voltage");
  a_trip_fast: assert property ($rose(jump_r[0]) && need == 2'h1
      && mode == MODE_SURGE && !uv && !blk && !(|phase_lost)
      |-> ##[1:2] trip)
    else $error("phase jump trip later than allowed");
  a_release_band: assert property (mode == MODE_OVER && pick_r[0]
      && 32'(meas[0].freq) * 32'(HYST_DEN)
      >= 32'(pickup_r) * 32'(HYST_DOWN) |=> pick_r[0])
    else $error("overfrequency pickup released inside band");
  a_alarm_drop: assert property (st_r == ST_SUPV && (!any_pick || blk)
      |=> !alarm && sup_cnt_r == '0)
    else $error("alarm or timer kept after pickup loss or block");
endmodule

// [testbench/fcvs_src.sv]
// three-phase voltage source model feeding the measurement inputs
module fcvs_src #(
  parameter int PER = 100
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stimulus settings
  input wire logic [15:0] freq,
  input wire logic low_v,
  input wire logic [23:0] len_j,
  input wire logic [2:0] go,
  // measurement outputs
  output fcvs_pkg::fcvs_meas_s [2:0] meas
);
  import fcvs_pkg::*;
  logic [23:0] cnt_r [3];
  logic [23:0] len_r [3];
  logic [2:0] pend_r;
  logic [2:0] zc_r;
  // go arms one displaced cycle on each selected phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 3'h0;
      zc_r <= 3'h0;
      foreach (cnt_r[i]) cnt_r[i] <= 24'h0;
      foreach (len_r[i]) len_r[i] <= PER[23:0];
    end else begin
      for (int i = 0; i < 3; i++) begin
        zc_r[i] <= (cnt_r[i] == len_r[i] - 24'h1);
        if (cnt_r[i] == len_r[i] - 24'h1) begin
          cnt_r[i] <= 24'h0;
          len_r[i] <= (pend_r[i] | go[i]) ? len_j : PER[23:0];
          pend_r[i] <= 1'b0;
        end else begin
          cnt_r[i] <= cnt_r[i] + 24'h1;
          pend_r[i] <= pend_r[i] | go[i];
        end
      end
    end
  end
  always_comb begin
    foreach (meas[i]) begin
      meas[i].freq = freq;
      meas[i].volt = low_v ? 16'h0010 : 16'h1000;
      meas[i].zc = zc_r[i];
    end
  end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the frequency change and vector surge monitor
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fcvs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ext_block, low_v;
  logic pready, pslverr, alarm, trip, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] phase_lost, go;
  logic [15:0] freq;
  logic [23:0] len_j;
  fcvs_meas_s [2:0] meas;
  int n_errors = 0;
  int samples_checked = 0;
  // surge cases: need, jumped phases, cycle length, lost, low, alarm, trip
  logic [1:0] c_need [8] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0};
  logic [2:0] c_mask [8] = '{3'h1, 3'h3, 3'h4, 3'h3, 3'h7, 3'h2, 3'h1, 3'h7};
  logic [7:0] c_len [8] = '{8'h6e, 8'h5a, 8'h6e, 8'h6e, 8'h5a, 8'h6e, 8'h66,
    8'h6e};
  logic [7:0] c_lost = 8'h20;
  logic [7:0] c_low = 8'h80;
  logic [7:0] c_ea = 8'h36;
  logic [7:0] c_et = 8'h16;
  fcvs_monitor #(.TICK_CYC(10)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .phase_lost(phase_lost), .ext_block(ext_block),
    .alarm(alarm), .trip(trip), .irq(irq));
  fcvs_src src (.pclk(pclk), .presetn(presetn), .freq(freq),
    .low_v(low_v), .len_j(len_j), .go(go), .meas(meas));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic at(input logic [1:0] x);
    chk({30'h0, alarm, trip}, {30'h0, x});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read as it stood at each rising edge
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        wrap_up();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic setf(input logic [15:0] v);
    @(posedge pclk);
    freq <= v;
    repeat (2) @(negedge pclk);
  endtask
  task automatic blk(input logic v);
    @(posedge pclk);
    ext_block <= v;
    repeat (4) @(negedge pclk);
  endtask
  task automatic watch(input int n, output logic a, output logic t);
    a = 1'b0;
    t = 1'b0;
    repeat (n) begin
      @(negedge pclk);
      a = a | alarm;
      t = t | trip;
    end
  endtask
  task automatic t_regs();
    rd(OFS_CTRL, {28'h0, CTRL_RST}, 1'b0);
    rd(OFS_PICKUP, {16'h0, PICKUP_RST}, 1'b0);
    rd(OFS_REFPER, {8'h0, REFPER_RST}, 1'b0);
    rd(OFS_IRQ_MASK, {30'h0, IRQ_MASK_RST}, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    wr(OFS_STATUS, 32'hf);
    rd(OFS_STATUS, 32'h0, 1'b0);
    wr(OFS_PICKUP, 32'h3e8);
    rd(OFS_PICKUP, 32'h3e8, 1'b0);
    wr(OFS_DF, 32'h32);
    wr(OFS_DT, 32'h14);
    wr(OFS_REFPER, 32'h64);
    wr(OFS_IRQ_MASK, 32'h3);
  endtask
  task automatic t_under();
    wr(OFS_CTRL, 32'h1);
    setf(16'h3de);
    at(2'h2);
    setf(16'h3ac);
    at(2'h3);
    rd(OFS_IRQ_STAT, 32'h3, 1'b0);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    // irq follows a mask change one edge later
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_IRQ_STAT, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    blk(1'b1);
    at(2'h0);
    rd(OFS_STATUS, 32'h0, 1'b0);
    setf(16'h3f2);
    blk(1'b0);
  endtask
  task automatic t_lock();
    setf(16'h3de);
    repeat (150) @(negedge pclk);
    at(2'h2);
    repeat (80) @(negedge pclk);
    at(2'h0);
    rd(OFS_STATUS, 32'hc, 1'b0);
    setf(16'h3ac);
    at(2'h0);
    setf(16'h3f2);
    setf(16'h3de);
    at(2'h2);
  endtask
  task automatic t_over();
    blk(1'b1);
    setf(16'h3e0);
    wr(OFS_CTRL, 32'h2);
    blk(1'b0);
    setf(16'h3f2);
    at(2'h2);
    setf(16'h3e8);
    at(2'h2);
    setf(16'h3e7);
    at(2'h0);
  endtask
  task automatic t_surge();
    logic a, t;
    blk(1'b1);
    wr(OFS_CTRL, 32'h3);
    blk(1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, {28'h0, c_need[i], 2'h3});
      @(posedge pclk);
      phase_lost <= {2'h0, c_lost[i]};
      low_v <= c_low[i];
      len_j <= {16'h0, c_len[i]};
      repeat (250) @(posedge pclk);
      go <= c_mask[i];
      @(posedge pclk);
      go <= 3'h0;
      watch(260, a, t);
      chk({30'h0, a, t}, {30'h0, c_ea[i], c_et[i]});
      @(posedge pclk);
      phase_lost <= 3'h0;
      low_v <= 1'b0;
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext_block = 1'b0;
    low_v = 1'b0;
    phase_lost = 3'h0;
    go = 3'h0;
    freq = 16'h3f2;
    len_j = 24'h64;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_under();
    t_lock();
    t_over();
    t_surge();
    wrap_up();
  end
endmodule
